/* afb_regs.svh */
`ifndef AFB_REGS_SVH
`define AFB_REGS_SVH
// Register offsets
`define AFB_OFS_CTRL 8'h00
`define AFB_OFS_STATUS 8'h04
`define AFB_OFS_REASON 8'h08
`define AFB_OFS_PHY_ID 8'h0C
`define AFB_OFS_NAME_HI 8'h10
`define AFB_OFS_NAME_LO 8'h14
`define AFB_OFS_ADDR_HI 8'h18
`define AFB_OFS_ADDR_LO 8'h1C
`define AFB_OFS_DEST_HI 8'h20
`define AFB_OFS_DEST_LO 8'h24
`define AFB_OFS_RATE 8'h28
`define AFB_OFS_ARB 8'h2C
`define AFB_OFS_RX_INFO 8'h30
// Control bits (write one to act)
`define AFB_CTRL_OPEN 0
`define AFB_CTRL_RETRY 1
`define AFB_CTRL_DONE 2
`define AFB_CTRL_CLR_ERR 3
// Reset values
`define AFB_RST_REASON 4'h0
`define AFB_RST_RATE 4'h8
// Frame constants
`define AFB_FT_IDENT 4'h0
`define AFB_FT_OPEN 4'h1
`define AFB_DEVT_END 3'h1
`define AFB_PROTO_SSP 3'h1
`define AFB_INI_BITS 8'h00
`define AFB_TGT_BITS 8'h08
`define AFB_CAP_B21 8'h01
`define AFB_CAP_B22 8'h01
`define AFB_RATE_G1 4'h8
`define AFB_RATE_G3 4'hA
`define AFB_PBC_MAX 8'hFF
`define AFB_AWT_US_MAX 16'h7FFF
`define AFB_AWT_MAX 16'hFFFF
`define AFB_CRC_INIT 32'hFFFFFFFF
`define AFB_CRC_POLY 32'h04C11DB7
// Timing
`define AFB_CLK_NS 25
`define AFB_US_NS 1000
`define AFB_US_CYC (`AFB_US_NS / `AFB_CLK_NS)
`define AFB_US_PER_MS 1000
`endif

/* afb_pkg.sv */
package afb_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_IDENT = 4'b0010,
		ST_OPEN = 4'b0100,
		ST_CONN = 4'b1000
	} afb_state_type;
	typedef logic [31:0] afb_dword_type;
endpackage

/* afb_frame_builder.sv */
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`include "afb_regs.svh"
module afb_frame_builder #(
	parameter int NUM_INIT = 4
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic phy_reset_done,
	input wire logic conn_open,
	input wire logic rx_break,
	input wire logic [31:0] rx_dword,
	input wire logic rx_valid,
	input wire logic rx_sof,
	input wire afb_pkg::afb_dword_type data_in,
	input wire logic data_in_valid,
	output logic data_ready,
	output afb_pkg::afb_dword_type tx_dword,
	output logic tx_valid,
	output logic tx_sof,
	output logic tx_eof,
	output logic tx_align,
	output logic tx_break_reply
);
	import afb_pkg::*;

	localparam int IW = (NUM_INIT > 1) ? $clog2(NUM_INIT) : 1;

	if (NUM_INIT < 2 || NUM_INIT > 64) begin : g_chk
		$error("NUM_INIT must be 2 to 64");
	end

	// Serial CRC step over one dword, msb first
	function automatic logic [31:0] crc_step(input logic [31:0] c,
		input logic [31:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 31; i >= 0; i--) begin
			if (r[31] ^ d[i])
				r = {r[30:0], 1'b0} ^ `AFB_CRC_POLY;
			else
				r = {r[30:0], 1'b0};
		end
		return r;
	endfunction

	afb_state_type state;
	logic [3:0] reason;
	logic [7:0] phy_id;
	logic [63:0] dev_name, sas_addr, dest_addr;
	logic [3:0] conn_rate, link_rate;
	logic ident_pend, open_pend, ident_sent, ident_rcvd, open_rcvd;
	logic crc_err, awt_run;
	logic [7:0] pbc;
	logic [15:0] awt;
	logic [5:0] us_cnt;
	logic [9:0] ms_cnt;
	logic [2:0] tx_idx, rx_idx;
	logic [31:0] frm [7];
	logic [31:0] crc, rx_crc, rx_d0, rx_src_hi, rx_src_lo;
	logic [1:0] rm_phase;
	logic [63:0] tbl_addr [NUM_INIT];
	logic [15:0] tbl_tag [NUM_INIT];
	logic [NUM_INIT-1:0] tbl_vld;
	logic [IW-1:0] tbl_ptr;
	logic [15:0] rx_tag_q;

	// Write decode
	logic wr_ctrl, do_open, do_retry, do_done, do_clr;
	assign wr_ctrl = reg_wr && reg_addr == `AFB_OFS_CTRL;
	assign do_open = wr_ctrl && reg_wdata[`AFB_CTRL_OPEN];
	assign do_retry = wr_ctrl && reg_wdata[`AFB_CTRL_RETRY];
	assign do_done = wr_ctrl && reg_wdata[`AFB_CTRL_DONE];
	assign do_clr = wr_ctrl && reg_wdata[`AFB_CTRL_CLR_ERR];

	// Configuration registers
	always_ff @(posedge clock) begin
		if (srst) begin
			reason <= `AFB_RST_REASON;
			phy_id <= 8'h00;
			dev_name <= 64'h0;
			sas_addr <= 64'h0;
			dest_addr <= 64'h0;
			conn_rate <= `AFB_RST_RATE;
			link_rate <= `AFB_RST_RATE;
		end else if (ce && reg_wr) begin
			case (reg_addr)
			`AFB_OFS_REASON: reason <= reg_wdata[3:0];
			`AFB_OFS_PHY_ID: phy_id <= reg_wdata[7:0];
			`AFB_OFS_NAME_HI: dev_name[63:32] <= reg_wdata;
			`AFB_OFS_NAME_LO: dev_name[31:0] <= reg_wdata;
			`AFB_OFS_ADDR_HI: sas_addr[63:32] <= reg_wdata;
			`AFB_OFS_ADDR_LO: sas_addr[31:0] <= reg_wdata;
			`AFB_OFS_DEST_HI: dest_addr[63:32] <= reg_wdata;
			`AFB_OFS_DEST_LO: dest_addr[31:0] <= reg_wdata;
			`AFB_OFS_RATE: begin
				// Out-of-range rates fall back to 1.5 Gbps
				if (reg_wdata[3:0] >= `AFB_RATE_G1 &&
					reg_wdata[3:0] <= `AFB_RATE_G3)
					conn_rate <= reg_wdata[3:0];
				else
					conn_rate <= `AFB_RATE_G1;
				if (reg_wdata[7:4] >= `AFB_RATE_G1 &&
					reg_wdata[7:4] <= `AFB_RATE_G3)
					link_rate <= reg_wdata[7:4];
				else
					link_rate <= `AFB_RATE_G1;
			end
			default: ;
			endcase
		end
	end

	// Register read, data valid only the cycle after the strobe
	always_ff @(posedge clock) begin
		if (srst) begin
			reg_rdata <= 32'h0;
		end else if (ce) begin
			reg_rdata <= 32'h0;
			if (reg_rd) begin
				case (reg_addr)
				`AFB_OFS_STATUS: reg_rdata <= {24'h0, crc_err,
					open_rcvd, ident_rcvd, ident_sent, awt_run,
					open_pend, ident_pend, conn_open};
				`AFB_OFS_REASON: reg_rdata <= {28'h0, reason};
				`AFB_OFS_PHY_ID: reg_rdata <= {24'h0, phy_id};
				`AFB_OFS_NAME_HI: reg_rdata <= dev_name[63:32];
				`AFB_OFS_NAME_LO: reg_rdata <= dev_name[31:0];
				`AFB_OFS_ADDR_HI: reg_rdata <= sas_addr[63:32];
				`AFB_OFS_ADDR_LO: reg_rdata <= sas_addr[31:0];
				`AFB_OFS_DEST_HI: reg_rdata <= dest_addr[63:32];
				`AFB_OFS_DEST_LO: reg_rdata <= dest_addr[31:0];
				`AFB_OFS_RATE: reg_rdata <= {24'h0, link_rate, conn_rate};
				`AFB_OFS_ARB: reg_rdata <= {8'h0, pbc, awt};
				`AFB_OFS_RX_INFO: reg_rdata <= {16'h0, rx_tag_q};
				default: reg_rdata <= 32'h0;
				endcase
			end
		end
	end

	// Pending frame requests; a new set beats a same-cycle take
	logic take_ident, take_open;
	assign take_ident = state == ST_IDLE && !conn_open && ident_pend;
	assign take_open = state == ST_IDLE && !conn_open && !ident_pend &&
		open_pend;
	always_ff @(posedge clock) begin
		if (srst) begin
			ident_pend <= 1'b0;
			open_pend <= 1'b0;
		end else if (ce) begin
			if (phy_reset_done)
				ident_pend <= 1'b1;
			else if (take_ident)
				ident_pend <= 1'b0;
			if (do_open || do_retry)
				open_pend <= 1'b1;
			else if (take_open || do_done)
				open_pend <= 1'b0;
		end
	end

	// Pathway-blocked retry count
	always_ff @(posedge clock) begin
		if (srst)
			pbc <= 8'h00;
		else if (ce && do_open)
			pbc <= 8'h00;
		else if (ce && do_retry && pbc != `AFB_PBC_MAX)
			pbc <= pbc + 8'h01;
	end

	// Arbitration wait timer; a retry leaves it running
	logic us_tick, ms_tick;
	assign us_tick = us_cnt == 6'(`AFB_US_CYC - 1);
	assign ms_tick = us_tick && ms_cnt == 10'(`AFB_US_PER_MS - 1);
	always_ff @(posedge clock) begin
		if (srst) begin
			awt_run <= 1'b0;
			awt <= 16'h0000;
			us_cnt <= 6'h00;
			ms_cnt <= 10'h000;
		end else if (ce) begin
			if (do_open) begin
				awt_run <= 1'b1;
				awt <= 16'h0000;
				us_cnt <= 6'h00;
				ms_cnt <= 10'h000;
			end else if (do_done || conn_open) begin
				awt_run <= 1'b0;
			end else if (awt_run) begin
				us_cnt <= us_tick ? 6'h00 : us_cnt + 6'h01;
				if (us_tick)
					ms_cnt <= ms_tick ? 10'h000 : ms_cnt + 10'h001;
				if (awt <= `AFB_AWT_US_MAX && awt != `AFB_AWT_US_MAX) begin
					if (us_tick)
						awt <= awt + 16'h0001;
				end else if (ms_tick && awt != `AFB_AWT_MAX) begin
					awt <= awt + 16'h0001;
				end
			end
		end
	end

	// Tag lookup for the addressed initiator
	logic [15:0] open_tag;
	always_comb begin
		open_tag = 16'h0000;
		for (int i = 0; i < NUM_INIT; i++)
			if (tbl_vld[i] && tbl_addr[i] == dest_addr)
				open_tag = tbl_tag[i];
	end

	// Frame images; reserved and unused fields are zero
	logic [31:0] id_img [7];
	logic [31:0] op_img [7];
	always_comb begin
		id_img[0] = {1'b0, `AFB_DEVT_END, `AFB_FT_IDENT, 4'h0, reason,
			`AFB_INI_BITS, `AFB_TGT_BITS};
		id_img[1] = dev_name[63:32];
		id_img[2] = dev_name[31:0];
		id_img[3] = sas_addr[63:32];
		id_img[4] = sas_addr[31:0];
		id_img[5] = {phy_id, `AFB_CAP_B21, `AFB_CAP_B22, 8'h00};
		id_img[6] = 32'h0;
		op_img[0] = {1'b0, `AFB_PROTO_SSP, `AFB_FT_OPEN, 4'h0,
			conn_rate, open_tag};
		op_img[1] = dest_addr[63:32];
		op_img[2] = dest_addr[31:0];
		op_img[3] = sas_addr[63:32];
		op_img[4] = sas_addr[31:0];
		op_img[5] = {8'h00, pbc, awt};
		op_img[6] = 32'h0;
	end

	// Frame sequencer; frames never begin inside a connection
	always_ff @(posedge clock) begin
		if (srst) begin
			state <= ST_IDLE;
			tx_idx <= 3'd0;
			ident_sent <= 1'b0;
			for (int i = 0; i < 7; i++)
				frm[i] <= 32'h0;
		end else if (ce) begin
			case (state)
			ST_IDLE: begin
				tx_idx <= 3'd0;
				if (conn_open) begin
					state <= ST_CONN;
				end else if (take_ident) begin
					state <= ST_IDENT;
					frm <= id_img;
				end else if (take_open) begin
					state <= ST_OPEN;
					frm <= op_img;
				end
			end
			ST_IDENT, ST_OPEN: begin
				tx_idx <= tx_idx + 3'd1;
				if (tx_idx == 3'd7) begin
					state <= ST_IDLE;
					if (state == ST_IDENT)
						ident_sent <= 1'b1;
				end
			end
			ST_CONN: begin
				if (!conn_open)
					state <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// Rate matching: ratio of link to connection rate sets ALIGN share
	logic [1:0] rm_ratio;
	logic rm_slot;
	always_comb begin
		rm_ratio = (link_rate > conn_rate) ? 2'(link_rate - conn_rate)
			: 2'd0;
		case (rm_ratio)
		2'd1: rm_slot = !rm_phase[0];
		2'd2: rm_slot = rm_phase == 2'd0;
		default: rm_slot = 1'b1;
		endcase
	end

	// Transmit stream; CRC accumulates as dwords go out
	logic framing;
	assign framing = state == ST_IDENT || state == ST_OPEN;
	always_ff @(posedge clock) begin
		if (srst) begin
			crc <= `AFB_CRC_INIT;
			tx_dword <= 32'h0;
			tx_valid <= 1'b0;
			tx_sof <= 1'b0;
			tx_eof <= 1'b0;
			tx_align <= 1'b0;
			data_ready <= 1'b0;
			rm_phase <= 2'd0;
		end else if (ce) begin
			tx_valid <= 1'b0;
			tx_sof <= 1'b0;
			tx_eof <= 1'b0;
			tx_align <= 1'b0;
			tx_dword <= 32'h0;
			data_ready <= 1'b0;
			rm_phase <= 2'd0;
			if (framing) begin
				tx_valid <= 1'b1;
				tx_sof <= tx_idx == 3'd0;
				tx_eof <= tx_idx == 3'd7;
				if (tx_idx == 3'd7) begin
					tx_dword <= ~crc;
				end else begin
					tx_dword <= frm[tx_idx];
					crc <= crc_step(tx_idx == 3'd0 ? `AFB_CRC_INIT : crc,
						frm[tx_idx]);
				end
			end else if (state == ST_CONN && conn_open) begin
				// Ready leads the stream by one cycle
				rm_phase <= rm_phase + 2'd1;
				data_ready <= rm_slot;
				tx_align <= !data_ready;
				tx_valid <= data_ready && data_in_valid;
				if (data_ready)
					tx_dword <= data_in;
			end
		end
	end

	// BREAK answered with BREAK_REPLY; power primitives never raised
	always_ff @(posedge clock) begin
		if (srst)
			tx_break_reply <= 1'b0;
		else if (ce)
			tx_break_reply <= rx_break;
	end

	// Receive check; only header, source address and tag are kept
	logic rx_good, rx_hit;
	logic [IW-1:0] rx_hit_idx;
	assign rx_good = rx_valid && rx_idx == 3'd7 && rx_dword == ~rx_crc;
	always_comb begin
		rx_hit = 1'b0;
		rx_hit_idx = '0;
		for (int i = 0; i < NUM_INIT; i++)
			if (tbl_vld[i] && tbl_addr[i] == {rx_src_hi, rx_src_lo}) begin
				rx_hit = 1'b1;
				rx_hit_idx = IW'(i);
			end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			rx_idx <= 3'd0;
			rx_crc <= `AFB_CRC_INIT;
			rx_d0 <= 32'h0;
			rx_src_hi <= 32'h0;
			rx_src_lo <= 32'h0;
		end else if (ce && rx_valid) begin
			rx_idx <= rx_sof ? 3'd1 : rx_idx + 3'd1;
			rx_crc <= crc_step(rx_sof ? `AFB_CRC_INIT : rx_crc, rx_dword);
			if (rx_sof)
				rx_d0 <= rx_dword;
			if (!rx_sof && rx_idx == 3'd3)
				rx_src_hi <= rx_dword;
			if (!rx_sof && rx_idx == 3'd4)
				rx_src_lo <= rx_dword;
		end
	end

	// Frame outcome flags; a new event beats a software clear
	always_ff @(posedge clock) begin
		if (srst) begin
			crc_err <= 1'b0;
			ident_rcvd <= 1'b0;
			open_rcvd <= 1'b0;
		end else if (ce) begin
			if (rx_valid && !rx_sof && rx_idx == 3'd7 && !rx_good)
				crc_err <= 1'b1;
			else if (do_clr)
				crc_err <= 1'b0;
			// Frame type sits in the low nibble of byte 0
			if (rx_good && rx_d0[27:24] == `AFB_FT_IDENT)
				ident_rcvd <= 1'b1;
			else if (do_clr)
				ident_rcvd <= 1'b0;
			if (rx_good && rx_d0[27:24] == `AFB_FT_OPEN)
				open_rcvd <= 1'b1;
			else if (do_clr)
				open_rcvd <= 1'b0;
		end
	end

	// Tag table, round-robin replacement when the source is new
	always_ff @(posedge clock) begin
		if (srst) begin
			tbl_vld <= '0;
			tbl_ptr <= '0;
			rx_tag_q <= 16'h0000;
			for (int i = 0; i < NUM_INIT; i++) begin
				tbl_addr[i] <= 64'h0;
				tbl_tag[i] <= 16'h0000;
			end
		end else if (ce && rx_good && !rx_sof &&
			rx_d0[27:24] == `AFB_FT_OPEN) begin
			rx_tag_q <= rx_d0[15:0];
			if (rx_hit) begin
				tbl_tag[rx_hit_idx] <= rx_d0[15:0];
			end else begin
				tbl_addr[tbl_ptr] <= {rx_src_hi, rx_src_lo};
				tbl_tag[tbl_ptr] <= rx_d0[15:0];
				tbl_vld[tbl_ptr] <= 1'b1;
				tbl_ptr <= (tbl_ptr == IW'(NUM_INIT - 1)) ? '0
					: tbl_ptr + IW'(1);
			end
		end
	end

	// Checks on the outgoing stream, the retry and wait counters and the break reply
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst || !ce);

	AST_FRAME_LEN: assert property (tx_sof |-> ##7 tx_eof)
		else $error("frame not eight dwords");
	AST_FRAME_TYPE: assert property (tx_sof |->
		tx_dword[27:24] == `AFB_FT_IDENT ||
		tx_dword[27:24] == `AFB_FT_OPEN)
		else $error("reserved frame type sent");
	AST_OUTSIDE_CONN: assert property (tx_sof |-> $past(!conn_open, 2))
		else $error("frame started inside connection");
	AST_IDENT_START: assert property (take_ident |=> state == ST_IDENT ##1
		tx_sof)
		else $error("identification frame not started");
	AST_IDENT_HDR: assert property (tx_sof && tx_dword[27:24] ==
		`AFB_FT_IDENT |-> tx_dword[31:24] == 8'h10 &&
		tx_dword[15:0] == 16'h0008)
		else $error("bad identification header");
	AST_ROLE_BITS: assert property (tx_sof && tx_dword[27:24] ==
		`AFB_FT_IDENT |-> tx_dword[15:8] == `AFB_INI_BITS ##7
		tx_eof)
		else $error("bad role bits");
	AST_CAPS: assert property (tx_sof && tx_dword[27:24] ==
		`AFB_FT_IDENT |-> ##5 tx_dword[23:8] == 16'h0101)
		else $error("bad capability bytes");
	AST_OPEN_HDR: assert property (tx_sof && tx_dword[27:24] ==
		`AFB_FT_OPEN |-> tx_dword[31:28] == 4'h1 &&
		tx_dword[19:16] >= `AFB_RATE_G1 &&
		tx_dword[19:16] <= `AFB_RATE_G3)
		else $error("bad connection request header");
	AST_PBC_SAT: assert property (pbc == `AFB_PBC_MAX && !do_open |=>
		pbc == `AFB_PBC_MAX)
		else $error("retry count wrapped");
	AST_AWT_US: assert property (awt_run && !do_open && !do_done &&
		!conn_open && awt < `AFB_AWT_US_MAX && !us_tick |=>
		$stable(awt))
		else $error("wait time moved off tick");
	AST_ALIGN: assert property (tx_align |-> !tx_valid)
		else $error("align overlaps data");
	AST_BREAK: assert property (rx_break |=> tx_break_reply)
		else $error("no break reply");

	COV_IDENT: cover property (take_ident ##2 tx_sof);
	COV_OPEN: cover property (take_open ##2 tx_sof);
	COV_ALIGN: cover property (tx_align ##1 tx_valid);
	COV_CRC_ERR: cover property ($rose(crc_err));
endmodule

/* afb_far_end.sv */
`timescale 1ns/1ps
// Initiator-side phy model: sends address frames and captures ours
module afb_far_end (
	input wire logic clock,
	input wire logic [31:0] tx_dword,
	input wire logic tx_valid,
	input wire logic tx_sof,
	input wire logic tx_eof,
	output logic [31:0] rx_dword,
	output logic rx_valid,
	output logic rx_sof,
	output logic rx_break
);
	typedef logic [31:0] afb_words_type [0:6];
	logic [31:0] frame [0:7];
	int frames_seen = 0;
	int frame_len = 8;

	// Lines idle at start; data line holds an arbitrary pattern
	initial begin
		rx_dword = 32'h5A5A5A5A;
		rx_valid = 1'h0;
		rx_sof = 1'h0;
		rx_break = 1'h0;
	end

	// CRC over bytes 0-27, msb first, inverted at the end
	function automatic logic [31:0] crc_of(input afb_words_type d);
		logic [31:0] c;
		logic fb;
		c = 32'hFFFFFFFF;
		for (int w = 0; w < 7; w++) begin
			for (int b = 31; b >= 0; b--) begin
				fb = c[31] ^ d[w][b];
				c = fb ? (c << 1) ^ 32'h04C11DB7 : c << 1;
			end
		end
		return ~c;
	endfunction

	// Capture each address frame; later connection data is skipped
	always @(posedge clock) begin
		if (tx_valid && tx_sof)
			frame_len = 0;
		if (tx_valid && frame_len < 8) begin
			frame[frame_len] = tx_dword;
			frame_len++;
		end
		if (tx_valid && tx_eof)
			frames_seen++;
	end

	// One 8-dword frame; bad spoils the CRC on purpose
	task automatic send_frame(input afb_words_type d, input logic bad);
		logic [31:0] c;
		c = crc_of(d) ^ {31'h0, bad};
		for (int k = 0; k < 8; k++) begin
			@(posedge clock);
			rx_valid <= 1'h1;
			rx_sof <= (k == 0);
			rx_dword <= (k < 7) ? d[k % 7] : c;
		end
		@(posedge clock);
		rx_valid <= 1'h0;
		rx_sof <= 1'h0;
		rx_dword <= ~rx_dword; // Released line must not look valid
	endtask

	// BREAK sequence flagged for one cycle
	task automatic send_break();
		@(posedge clock);
		rx_break <= 1'h1;
		@(posedge clock);
		rx_break <= 1'h0;
	endtask
endmodule

/* afb_frame_builder_test.sv */
`timescale 1ns/1ps
`include "afb_regs.svh"
module afb_frame_builder_test;
	import afb_pkg::*;
	localparam logic [63:0] dev_name = 64'h1122334455667788;
	localparam logic [63:0] own_addr = 64'h5000AAAA0000BBBB;
	localparam logic [63:0] ini_addr = 64'h5000CCCC0000DDDD;
	logic clock = 1'h0;
	logic srst = 1'h1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic phy_reset_done = 1'h0;
	logic conn_open = 1'h0;
	afb_dword_type data_in = 32'h0;
	logic data_in_valid = 1'h0;
	logic [31:0] reg_rdata, rx_dword;
	logic rx_valid, rx_sof, rx_break, data_ready, tx_valid, tx_sof;
	logic tx_eof, tx_align, tx_break_reply;
	afb_dword_type tx_dword;
	logic [31:0] exp_f [0:6];
	logic [31:0] rx_f [0:6];
	logic [31:0] rd_val;
	logic [7:0] whys [0:4] = '{8'h00, 8'h02, 8'h04, 8'h07, 8'h08};
	logic win = 1'h0;
	logic [31:0] exp_q [$];
	int n_rdy, n_al, n_tv, n, t0, t1;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;

	afb_frame_builder #(.NUM_INIT(4)) DUT (
		.clock(clock), .srst(srst), .ce(1'h1), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .phy_reset_done(phy_reset_done),
		.conn_open(conn_open), .rx_break(rx_break), .rx_dword(rx_dword),
		.rx_valid(rx_valid), .rx_sof(rx_sof), .data_in(data_in),
		.data_in_valid(data_in_valid), .data_ready(data_ready),
		.tx_dword(tx_dword), .tx_valid(tx_valid), .tx_sof(tx_sof),
		.tx_eof(tx_eof), .tx_align(tx_align),
		.tx_break_reply(tx_break_reply)
	);

	afb_far_end u_far (
		.clock(clock), .tx_dword(tx_dword), .tx_valid(tx_valid),
		.tx_sof(tx_sof), .tx_eof(tx_eof), .rx_dword(rx_dword),
		.rx_valid(rx_valid), .rx_sof(rx_sof), .rx_break(rx_break)
	);

	// 40 MHz clock
	always #12.5 clock = ~clock;

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Hang guard, far above the expected run of some 3700 cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			tally_and_finish();
		end
	end

	// Connection data: count pacing, match every dword in order
	always @(posedge clock) begin
		if (win) begin
			n_rdy += data_ready;
			n_al += tx_align;
			n_tv += tx_valid;
		end
		if (conn_open && tx_valid)
			cmp(tx_dword, exp_q.pop_front());
		if (tx_sof)
			cmp(conn_open, 1'h0);
		if (data_ready && data_in_valid) begin
			exp_q.push_back(data_in);
			data_in <= data_in + 32'h1;
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clock);
		reg_wr <= 1'h0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clock);
		reg_rd <= 1'h0;
		@(posedge clock);
		rd_val = reg_rdata;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		cmp(rd_val, exp);
	endtask

	// Bounded wait for the far end to count frame number k
	task automatic wait_frames(input int k);
		for (int i = 0; i < 400 && u_far.frames_seen < k; i++)
			@(posedge clock);
		cmp(u_far.frames_seen, k);
	endtask

	task automatic fill(input logic [63:0] a, input logic [63:0] b);
		exp_f[1] = a[63:32];
		exp_f[2] = a[31:0];
		exp_f[3] = b[63:32];
		exp_f[4] = b[31:0];
	endtask

	task automatic exp_ident(input logic [7:0] why);
		exp_f[0] = {8'h10, why, 8'h00, 8'h08};
		fill(dev_name, own_addr);
		exp_f[5] = {8'h03, 8'h01, 8'h01, 8'h00};
		exp_f[6] = 32'h0;
	endtask

	task automatic exp_open(input logic [3:0] r, input logic [7:0] pbc);
		exp_f[0] = {8'h11, 4'h0, r, 16'hBEEF};
		fill(ini_addr, own_addr);
		exp_f[5] = {8'h00, pbc, 16'h0000};
		exp_f[6] = 32'h0;
	endtask

	// Whole captured frame, its length and its CRC
	task automatic chk_frame();
		for (int k = 0; k < 7; k++)
			cmp(u_far.frame[k], exp_f[k]);
		cmp(u_far.frame[7], u_far.crc_of(exp_f));
		cmp(u_far.frame_len, 8);
	endtask

	initial begin
		repeat (6) @(posedge clock);
		srst <= 1'h0;
		// Reset values, control and unmapped places read zero
		rchk(`AFB_OFS_REASON, 32'h0);
		rchk(`AFB_OFS_RATE, 32'h88);
		rchk(`AFB_OFS_CTRL, 32'h0);
		rchk(8'h3C, 32'h0);
		rchk(`AFB_OFS_ARB, 32'h0);
		wr(`AFB_OFS_NAME_HI, dev_name[63:32]);
		wr(`AFB_OFS_NAME_LO, dev_name[31:0]);
		wr(`AFB_OFS_ADDR_HI, own_addr[63:32]);
		wr(`AFB_OFS_ADDR_LO, own_addr[31:0]);
		wr(`AFB_OFS_DEST_HI, ini_addr[63:32]);
		wr(`AFB_OFS_DEST_LO, ini_addr[31:0]);
		wr(`AFB_OFS_PHY_ID, 32'h3);
		// Identification for each of five reasons; the first held off by a link
		for (int i = 0; i < 5; i++) begin
			wr(`AFB_OFS_REASON, {24'h0, whys[i]});
			conn_open <= (i == 0);
			@(posedge clock);
			phy_reset_done <= 1'h1;
			@(posedge clock);
			phy_reset_done <= 1'h0;
			repeat (12) @(posedge clock);
			if (i == 0)
				cmp(u_far.frames_seen, 0);
			conn_open <= 1'h0;
			wait_frames(i + 1);
			exp_ident(whys[i]);
			chk_frame();
		end
		// Initiator opens to us; a frame with a bad CRC is not acted on
		rx_f = '{32'h9108BEEF, own_addr[63:32], own_addr[31:0],
			ini_addr[63:32], ini_addr[31:0], 32'h0, 32'h0};
		u_far.send_frame(rx_f, 1'h0);
		rchk(`AFB_OFS_RX_INFO, 32'h0000BEEF);
		rx_f[0] = 32'h91081234;
		u_far.send_frame(rx_f, 1'h1);
		rchk(`AFB_OFS_RX_INFO, 32'h0000BEEF);
		rd(`AFB_OFS_STATUS);
		cmp(rd_val & 32'hC0, 32'hC0);
		wr(`AFB_OFS_CTRL, 32'h8);
		rd(`AFB_OFS_STATUS);
		cmp(rd_val & 32'h80, 32'h0);
		// Identification and request at once: identification first
		n = u_far.frames_seen;
		@(posedge clock);
		reg_addr <= `AFB_OFS_CTRL;
		reg_wdata <= 32'h1;
		reg_wr <= 1'h1;
		phy_reset_done <= 1'h1;
		@(posedge clock);
		reg_wr <= 1'h0;
		phy_reset_done <= 1'h0;
		wait_frames(n + 1);
		exp_ident(8'h08);
		chk_frame();
		wait_frames(n + 2);
		exp_open(4'h8, 8'h00);
		chk_frame();
		// Each connection rate, each a fresh request
		for (int r = 8; r < 11; r++) begin
			wr(`AFB_OFS_RATE, {24'h0, 4'hA, r[3:0]});
			wr(`AFB_OFS_CTRL, 32'h1);
			t0 = cycles;
			wait_frames(n + r - 5);
			exp_open(r[3:0], 8'h00);
			chk_frame();
		end
		wr(`AFB_OFS_RATE, 32'hAB);
		rchk(`AFB_OFS_RATE, 32'hA8);
		// Pathway-blocked retries count up and stop at FFh
		for (int i = 1; i < 258; i++) begin
			wr(`AFB_OFS_CTRL, 32'h2);
			wait_frames(n + 5 + i);
			// Wait time runs on, so only zone group and count
			cmp(u_far.frame[5][31:16],
				{8'h00, (i > 255) ? 8'hFF : i[7:0]});
		end
		// Wait time kept across retries, one step per microsecond
		t1 = (cycles - t0) / 40;
		cmp(u_far.frame[5][15:0] inside {[t1 - 2 : t1]}, 1'h1);
		wr(`AFB_OFS_CTRL, 32'h1);
		wait_frames(n + 263);
		exp_open(4'h8, 8'h00);
		chk_frame();
		// Done stops the timer and cancels a request held off by a link
		rd(`AFB_OFS_STATUS);
		cmp(rd_val & 32'h8, 32'h8);
		conn_open <= 1'h1;
		wr(`AFB_OFS_CTRL, 32'h1);
		wr(`AFB_OFS_CTRL, 32'h4);
		conn_open <= 1'h0;
		repeat (16) @(posedge clock);
		cmp(u_far.frames_seen, n + 263);
		rd(`AFB_OFS_STATUS);
		cmp(rd_val & 32'hC, 32'h0);
		// BREAK answered by one reply pulse
		u_far.send_break();
		@(posedge clock);
		cmp(tx_break_reply, 1'h1);
		@(posedge clock);
		cmp(tx_break_reply, 1'h0);
		// Pacing by link to connection rate ratio, ALIGN in the gaps
		for (int r = 8; r < 11; r++) begin
			wr(`AFB_OFS_RATE, {24'h0, 4'hA, r[3:0]});
			conn_open <= 1'h1;
			data_in_valid <= 1'h1;
			exp_q.delete();
			repeat (8) @(posedge clock);
			n_rdy = 0;
			n_al = 0;
			n_tv = 0;
			win <= 1'h1;
			repeat (40) @(posedge clock);
			win <= 1'h0;
			@(posedge clock);
			cmp(n_rdy, 40 >> (10 - r));
			cmp(n_al, 40 - (40 >> (10 - r)));
			cmp(n_tv, 40 >> (10 - r));
			conn_open <= 1'h0;
			data_in_valid <= 1'h0;
			repeat (4) @(posedge clock);
		end
		tally_and_finish();
	end
endmodule
